//--- dpc_core.sv
// Power-down and host mode control of a tone transceiver, top level.
// Assumes all pins synchronous to core_clk_i and an APB master for register access.
`timescale 1ns/100ps
module dpc_core
  import dpc_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Device pins
  input  wire logic        bus_style_strap_i,
  input  wire logic        power_down_in_i,
  input  wire logic        osc_clk_i,
  output logic             clock_buffer_out_o,
  input  wire logic        read_or_bus_clock_in_i,
  input  wire logic        write_or_direction_in_i,
  input  wire logic        chip_select_n_i,
  input  wire logic        addr_latch_or_addr_i,
  input  wire logic [3:0]  host_data_i,
  output logic      [3:0]  host_data_o,
  output logic             host_data_oe_o,
  // Analog front end
  input  wire logic        digit_raw_i,
  input  wire logic        tone_raw_i,
  input  wire logic        fax_raw_i,
  input  wire logic [3:0]  rx_digit_i,
  output logic             tone_gen_en_o,
  output logic             digit_gen_en_o,
  output logic      [3:0]  tx_digit_o,
  output logic             fax_detect_out_o,
  output logic             tone_detect_out_o
);

  // ==========================================================================
  // Helpers
  function automatic logic apb_hit(input logic [7:0] addr, input logic [7:0] off);
    apb_hit = (addr == off);
  endfunction

  dpc_qual_if  qif ();
  dpc_pwr_type pwr_q;
  logic [3:0]  control_reg_q, tx_digit_reg_q, rx_digit_q, hb_rdata_q;
  logic [31:0] prdata_q;
  logic        style_q, rd_prev_q, wr_prev_q, ale_prev_q, hb_addr_q, digit_prev_q;
  logic        fax_q, tone_q, tgen_q, dgen_q, clk_buf_q;

  // ==========================================================================
  // Power state; reset doubles as power-down so the device wakes cleared
  wire pd_w  = rst_i | power_down_in_i;
  wire run_w = (pwr_q == PWR_RUN);

  always_ff @(posedge core_clk_i) begin
    case (pwr_q)
      PWR_DOWN: pwr_q <= pd_w ? PWR_DOWN : PWR_RUN;
      PWR_RUN:  pwr_q <= pd_w ? PWR_DOWN : PWR_RUN;
      default:  pwr_q <= PWR_DOWN;
    endcase
  end

  // ==========================================================================
  // Host 4-bit bus decode; pin roles depend on the sampled strap
  wire hb_sel   = !chip_select_n_i;
  wire rd_fall  = rd_prev_q & !read_or_bus_clock_in_i;
  wire wr_rise  = !wr_prev_q & write_or_direction_in_i;
  wire ale_fall = ale_prev_q & !addr_latch_or_addr_i;
  wire hb_addr  = style_q ? hb_addr_q : addr_latch_or_addr_i;
  // Strobe style writes at end of write strobe; shared style at bus clock fall
  wire hb_wr    = hb_sel & !pd_w & (style_q ? wr_rise
                                            : (rd_fall & !write_or_direction_in_i));
  wire hb_drive = hb_sel & (style_q ? !read_or_bus_clock_in_i
                                    : (write_or_direction_in_i & read_or_bus_clock_in_i));
  wire hb_wr_ctrl  = hb_wr & (hb_addr == HB_ADDR_CTRL);
  wire hb_wr_txdig = hb_wr & (hb_addr != HB_ADDR_CTRL);

  // Strap is sampled every cycle; it is expected never to move
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      style_q    <= 1'b0;
      rd_prev_q  <= 1'b1;
      wr_prev_q  <= 1'b1;
      ale_prev_q <= 1'b0;
      hb_addr_q  <= 1'b0;
    end else begin
      style_q    <= bus_style_strap_i;
      rd_prev_q  <= read_or_bus_clock_in_i;
      wr_prev_q  <= write_or_direction_in_i;
      ale_prev_q <= addr_latch_or_addr_i;
      hb_addr_q  <= ale_fall ? host_data_i[0] : hb_addr_q;
    end
  end

  // ==========================================================================
  // APB decode: writes land on the access-phase edge, reads loaded at setup
  wire apb_setup  = psel_i & !penable_i;
  wire apb_access = psel_i & penable_i;
  wire apb_mapped = apb_hit(paddr_i, ADDR_CTRL) | apb_hit(paddr_i, ADDR_TXDIG)
                  | apb_hit(paddr_i, ADDR_STATUS) | apb_hit(paddr_i, ADDR_RXDIG)
                  | apb_hit(paddr_i, ADDR_CFG);
  wire apb_wr     = apb_access & pwrite_i & !pd_w;
  wire apb_wr_ctrl  = apb_wr & apb_hit(paddr_i, ADDR_CTRL);
  wire apb_wr_txdig = apb_wr & apb_hit(paddr_i, ADDR_TXDIG);

  // Status reads as no detection whenever powered down
  logic [3:0] status_w;
  assign status_w[ST_DIGIT_BIT] = !pd_w & qif.det[DET_DIGIT];
  assign status_w[ST_TONE_BIT]  = !pd_w & qif.det[DET_TONE];
  assign status_w[ST_FAX_BIT]   = !pd_w & qif.det[DET_FAX];
  assign status_w[ST_PD_BIT]    = pd_w;

  wire [31:0] cfg_w  = {30'h0, power_down_in_i, style_q};
  wire [31:0] rd_mux = apb_hit(paddr_i, ADDR_CTRL)   ? {28'h0, control_reg_q}  :
                       apb_hit(paddr_i, ADDR_TXDIG)  ? {28'h0, tx_digit_reg_q} :
                       apb_hit(paddr_i, ADDR_STATUS) ? {28'h0, status_w}       :
                       apb_hit(paddr_i, ADDR_RXDIG)  ? {28'h0, rx_digit_q}     :
                       apb_hit(paddr_i, ADDR_CFG)    ? cfg_w : 32'h0;

  assign pready_o  = apb_access;  // No wait states
  assign pslverr_o = apb_access & !apb_mapped;
  assign prdata_o  = prdata_q;

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      prdata_q <= 32'h0;
    end else if (apb_setup) begin
      prdata_q <= rd_mux;
    end
  end

  // ==========================================================================
  // Control and transmit-digit registers; host pins win over APB on collision
  always_ff @(posedge core_clk_i) begin
    if (pd_w) begin
      control_reg_q  <= CTRL_RST;
      tx_digit_reg_q <= TXDIG_RST;
    end else begin
      control_reg_q  <= hb_wr_ctrl  ? host_data_i :
                        apb_wr_ctrl ? pwdata_i[3:0] : control_reg_q;
      tx_digit_reg_q <= hb_wr_txdig  ? host_data_i :
                        apb_wr_txdig ? pwdata_i[3:0] : tx_digit_reg_q;
    end
  end

  // ==========================================================================
  // Detector qualification; timers held clear throughout power-down
  assign qif.raw = {fax_raw_i, tone_raw_i, digit_raw_i};
  assign qif.clr = {NUM_DET{pd_w}};

  dpc_det_qual u_qual (
    .core_clk_i (core_clk_i),
    .rst_i      (rst_i),
    .q          (qif.qual)
  );

  // Received digit captured on each new qualified digit
  wire digit_rise = qif.det[DET_DIGIT] & !digit_prev_q;

  // Generators have their own enables; fax and tone pins share the output enable bit, and no lane blocks another
  always_ff @(posedge core_clk_i) begin
    if (pd_w) begin
      rx_digit_q   <= 4'h0;
      digit_prev_q <= 1'b0;
      fax_q        <= 1'b0;
      tone_q       <= 1'b0;
      tgen_q       <= 1'b0;
      dgen_q       <= 1'b0;
    end else begin
      rx_digit_q   <= digit_rise ? rx_digit_i : rx_digit_q;
      digit_prev_q <= qif.det[DET_DIGIT];
      fax_q        <= qif.det[DET_FAX] & control_reg_q[CTRL_DOEN_BIT];
      tone_q       <= qif.det[DET_TONE] & control_reg_q[CTRL_DOEN_BIT];
      tgen_q       <= control_reg_q[CTRL_TGEN_BIT];
      dgen_q       <= control_reg_q[CTRL_DGEN_BIT];
    end
  end

  // Host read data
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      hb_rdata_q <= 4'h0;
    end else begin
      hb_rdata_q <= (hb_addr == HB_ADDR_CTRL) ? status_w : rx_digit_q;
    end
  end

  // Oscillator copy runs through reset so a chained device never loses its clock
  always_ff @(posedge core_clk_i) begin
    clk_buf_q <= osc_clk_i;
  end

  assign host_data_o        = hb_rdata_q;
  assign host_data_oe_o     = hb_drive;
  assign clock_buffer_out_o = clk_buf_q;
  assign fax_detect_out_o   = fax_q;
  assign tone_detect_out_o  = tone_q;
  assign tone_gen_en_o      = tgen_q;
  assign digit_gen_en_o     = dgen_q;
  assign tx_digit_o         = tx_digit_reg_q;

  // ==========================================================================
  // Checks
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  sequence shared_write_s;
    !style_q && hb_sel && !write_or_direction_in_i && rd_fall && !power_down_in_i;
  endsequence

  pd_clears_regs_a: assert property (
    power_down_in_i |=> control_reg_q == 4'h0 && tx_digit_reg_q == 4'h0)
    else $error("registers not cleared in power-down");
  pd_quiet_pins_a: assert property (
    power_down_in_i |=> !fax_detect_out_o && !tone_detect_out_o)
    else $error("detect pins active in power-down");
  pd_status_a: assert property (
    power_down_in_i |-> status_w == 4'h8)
    else $error("status not idle in power-down");
  pd_halts_gen_a: assert property (
    power_down_in_i |=> !tone_gen_en_o && !digit_gen_en_o)
    else $error("generators running in power-down");
  wake_runs_a: assert property (
    $fell(power_down_in_i) |=> run_w)
    else $error("no run after power-down release");
  regs_hold_a: assert property (
    !power_down_in_i && !hb_wr && !apb_wr ##1 !power_down_in_i |-> $stable(control_reg_q))
    else $error("control register changed without a write");
  tone_follows_a: assert property (
    !power_down_in_i [*2] |-> tone_gen_en_o == $past(control_reg_q[CTRL_TGEN_BIT]))
    else $error("tone enable does not follow control bit");
  clk_buffer_a: assert property (
    ##1 clock_buffer_out_o == $past(osc_clk_i))
    else $error("clock output not a copy of oscillator");
  strobe_drive_a: assert property (
    style_q && hb_sel && !read_or_bus_clock_in_i |-> host_data_oe_o)
    else $error("data pins not driven on read strobe");
  shared_ctrl_wr_a: assert property (
    shared_write_s and addr_latch_or_addr_i |=> control_reg_q == $past(host_data_i))
    else $error("shared-style write missed control register");

endmodule // dpc_core

//--- dpc_pkg.sv
// Constants, register map and types for the tone transceiver power and host mode control.
// Assumes a 100 MHz core clock and APB with 32-bit data; no timescale in packages.
package dpc_pkg;

  // ==========================================================================
  // APB register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_TXDIG  = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_RXDIG  = 8'h0c;
  localparam logic [7:0] ADDR_CFG    = 8'h10;

  // ==========================================================================
  // Field positions
  localparam int CTRL_TGEN_BIT = 0;  // Progress-tone generator enable
  localparam int CTRL_DGEN_BIT = 1;  // Digit generator enable
  localparam int CTRL_DOEN_BIT = 2;  // Detector pin output enable
  localparam int ST_DIGIT_BIT  = 0;
  localparam int ST_TONE_BIT   = 1;
  localparam int ST_FAX_BIT    = 2;
  localparam int ST_PD_BIT     = 3;
  localparam int CFG_STRAP_BIT = 0;
  localparam int CFG_PD_BIT    = 1;

  // ==========================================================================
  // Reset values and host bus address codes
  localparam logic [3:0] CTRL_RST     = 4'h0;
  localparam logic [3:0] TXDIG_RST    = 4'h0;
  localparam logic       HB_ADDR_CTRL = 1'b1;  // Address high selects control/status

  // ==========================================================================
  // Detector lanes and qualification timing
  localparam int DET_DIGIT      = 0;
  localparam int DET_TONE       = 1;
  localparam int DET_FAX        = 2;
  localparam int NUM_DET        = 3;
  localparam int CLK_MHZ        = 100;
  localparam int QUAL_TIME_US   = 40;
  localparam int QUAL_CYCLES    = QUAL_TIME_US * CLK_MHZ;
  localparam int QUAL_CNT_W     = 12;

  // ==========================================================================
  // Power state, one-hot
  typedef enum logic [1:0] {
    PWR_DOWN = 2'b01,
    PWR_RUN  = 2'b10
  } dpc_pwr_type;

endpackage

//--- dpc_qual_if.sv
// Interface between the core and the detector qualification timers.
// Assumes both ends run on the same core clock.
`timescale 1ns/100ps
interface dpc_qual_if import dpc_pkg::*; ();
  logic [NUM_DET-1:0] raw;  // Unqualified detector levels
  logic [NUM_DET-1:0] clr;  // Timer reset, held during power-down
  logic [NUM_DET-1:0] det;  // Qualified detection

  modport core (output raw, output clr, input det);
  modport qual (input raw, input clr, output det);
endinterface

//--- dpc_det_qual.sv
// Qualification timers, one lane per detector.
// Assumes raw levels are synchronous to core_clk_i.
`timescale 1ns/100ps
module dpc_det_qual
  import dpc_pkg::*;
(
  input  wire logic core_clk_i,
  input  wire logic rst_i,
  dpc_qual_if.qual  q
);

  // ==========================================================================
  // Per-lane counters: a lane reports only after its raw level held long enough
  genvar g;
  generate
    for (g = 0; g < NUM_DET; g++) begin : g_lane
      logic [QUAL_CNT_W-1:0] cnt_q;
      logic                  det_q;
      wire                   done_w = (cnt_q == QUAL_CNT_W'(QUAL_CYCLES));

      // Counter restarts on any dropout so glitches never qualify
      always_ff @(posedge core_clk_i) begin
        if (rst_i || q.clr[g] || !q.raw[g]) begin
          cnt_q <= '0;
          det_q <= 1'b0;
        end else begin
          cnt_q <= done_w ? cnt_q : cnt_q + 1'b1;
          det_q <= done_w;
        end
      end
      assign q.det[g] = det_q;

      clr_drops_det_a: assert property (
        @(posedge core_clk_i) disable iff (rst_i) q.clr[g] |=> !q.det[g] && cnt_q == '0)
        else $error("detector not reset by clear");
    end
  endgenerate

endmodule // dpc_det_qual

//--- dpc_host_model.sv
// Partner model: a microcontroller on the 4-bit host bus, both bus styles.
// Assumes the bench resolves the shared data lines from both enables.
`timescale 1ns/100ps
module dpc_host_model (
  input  wire logic       core_clk_i,
  input  wire logic       style_i,
  input  wire logic [3:0] dev_data_i,
  input  wire logic       dev_oe_i,
  output logic            rd_clk_o,
  output logic            wr_dir_o,
  output logic            cs_n_o,
  output logic            addr_o,
  output logic            data_oe_o,
  output logic      [3:0] data_o
);
  // ==========================================================================
  // Bus cycles
  logic [3:0] drv_q;
  logic [3:0] junk_q = 4'h5;
  // Released lines toggle so that stale data never passes for valid data
  always @(posedge core_clk_i) junk_q <= ~junk_q;
  assign data_o = data_oe_o ? drv_q : junk_q;
  initial {rd_clk_o, wr_dir_o, cs_n_o, addr_o, data_oe_o, drv_q} = 9'h0c0;
  // Idle: bus clock low, read strobe high, write strobe high
  task automatic rel();
    cs_n_o <= 1'b1;
    data_oe_o <= 1'b0;
    rd_clk_o <= style_i;
    wr_dir_o <= 1'b1;
  endtask
  // Address rides on data bit 0 and is taken as the latch falls
  task automatic latch(input logic a);
    @(posedge core_clk_i);
    addr_o <= 1'b1;
    drv_q <= {3'h0, a};
    data_oe_o <= 1'b1;
    @(posedge core_clk_i);
    addr_o <= 1'b0;
  endtask
  // Host write of one register; the device takes it and obeys
  task automatic wr(input logic a, input logic [3:0] d);
    if (style_i) begin
      latch(a);
      @(posedge core_clk_i);
      cs_n_o <= 1'b0;
      wr_dir_o <= 1'b0;
      drv_q <= d;
      @(posedge core_clk_i);
      wr_dir_o <= 1'b1;
    end else begin
      @(posedge core_clk_i);
      {cs_n_o, wr_dir_o, addr_o, data_oe_o, rd_clk_o} <= {2'b00, a, 2'b11};
      drv_q <= d;
      @(posedge core_clk_i);
      rd_clk_o <= 1'b0;
    end
    @(posedge core_clk_i);
    rel();
  endtask
  // Host read; data lags the select by one cycle, so three cycles are held
  task automatic rd(input logic a, output logic [3:0] d, output logic oe);
    if (style_i) latch(a);
    @(posedge core_clk_i);
    {data_oe_o, cs_n_o, wr_dir_o} <= 3'b001;
    addr_o <= style_i ? 1'b0 : a;
    rd_clk_o <= ~style_i;
    repeat (3) @(posedge core_clk_i);
    d = dev_data_i;
    oe = dev_oe_i;
    rel();
  endtask
endmodule // dpc_host_model

//--- test_dtmf_power_and_host_mode_ctrl.sv
// Self-checking bench for the tone transceiver power and host mode block.
// Assumes the host model drives the 4-bit bus; the bench drives APB and pins.
`timescale 1ns/100ps
module test_dtmf_power_and_host_mode_ctrl
  import dpc_pkg::*;
;
  logic        clk = 1'b0, rst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
  logic        strap = 1'b0, pd = 1'b0, osc = 1'b0, lerr, v, ho;
  logic        pready, pslverr, cbo, hd_oe, tg, dg, fxo, tdo, m_rd, m_wr, m_cs, m_al, m_oe;
  logic [2:0]  raw = 3'h0;
  logic [3:0]  rxd = 4'h0, hv, txd, hd_o, m_d;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  wire  [3:0]  pins = {tg, dg, fxo, tdo};
  wire  [3:0]  hbus = (hd_oe && !m_oe) ? hd_o : m_d;
  int          failures = 0, total_checks = 0;

  // ==========================================================================
  // Clocks, instances, tasks
  initial forever #5 clk = ~clk;
  always @(posedge clk) osc <= ~osc;
  dpc_core i_dpc_core (
    .core_clk_i(clk), .rst_i(rst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .bus_style_strap_i(strap), .power_down_in_i(pd),
    .osc_clk_i(osc), .clock_buffer_out_o(cbo), .read_or_bus_clock_in_i(m_rd),
    .write_or_direction_in_i(m_wr), .chip_select_n_i(m_cs), .addr_latch_or_addr_i(m_al),
    .host_data_i(hbus), .host_data_o(hd_o), .host_data_oe_o(hd_oe), .digit_raw_i(raw[0]),
    .tone_raw_i(raw[1]), .fax_raw_i(raw[2]), .rx_digit_i(rxd), .tone_gen_en_o(tg),
    .digit_gen_en_o(dg), .tx_digit_o(txd), .fax_detect_out_o(fxo), .tone_detect_out_o(tdo)
  );
  dpc_host_model i_dpc_host_model (
    .core_clk_i(clk), .style_i(strap), .dev_data_i(hd_o), .dev_oe_i(hd_oe), .rd_clk_o(m_rd),
    .wr_dir_o(m_wr), .cs_n_o(m_cs), .addr_o(m_al), .data_oe_o(m_oe), .data_o(m_d)
  );
  task automatic chkw(input string n, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk(input string n, input logic [3:0] e, input logic [3:0] g);
    chkw(n, {28'h0, e}, {28'h0, g});
  endtask
  // APB master; the request holds until pready is seen high at an edge
  // Only the watchdog bounds the wait, the master accepts any number of wait states
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    {psel, pwr, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rv = prdata;
    lerr = pslverr;
    {psel, pen} <= 2'b00;
  endtask
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chkw(n, e, rv);
  endtask
  // The strap only moves while reset holds the block
  task automatic boot(input logic s);
    @(posedge clk);
    {rst, strap} <= {1'b1, s};
    repeat (8) @(posedge clk);
    i_dpc_host_model.rel();  // Idle strobe levels follow the new strap
    {rst, pd} <= 2'b01;
    @(posedge clk);
    pd <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Watchdog: the tests need about 4200 cycles
  initial begin
    #200000;
    failures++;
    summarize();
  end

  // ==========================================================================
  // Tests
  initial begin
    boot(1'b0);
    apb(1'b1, ADDR_CTRL, 32'h7);
    apb(1'b1, ADDR_TXDIG, 32'h5);
    rdc("ctrl", ADDR_CTRL, 32'h7);
    chk("pins", 4'hc, pins);
    rdc("unmapped", 8'h14, 32'h0);
    chk("slverr", 4'h1, {3'h0, lerr});
    rdc("cfg", ADDR_CFG, 32'h0);
    {raw, rxd} <= {3'h7, 4'hb};
    repeat (QUAL_CYCLES + 20) @(posedge clk);
    chk("pins", 4'hf, pins);
    rdc("status", ADDR_STATUS, 32'h7);
    rdc("rxdig", ADDR_RXDIG, 32'hb);
    pd <= 1'b1;
    repeat (3) @(posedge clk);
    chk("pins", 4'h0, pins);
    chk("txd", 4'h0, txd);
    rdc("status", ADDR_STATUS, 32'h8);
    apb(1'b1, ADDR_CTRL, 32'h7);
    pd <= 1'b0;
    repeat (2) @(posedge clk);
    rdc("ctrl", ADDR_CTRL, 32'h0);
    rdc("txdig", ADDR_TXDIG, 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h4);
    repeat (100) @(posedge clk);
    rdc("status", ADDR_STATUS, 32'h0);
    chk("pins", 4'h0, pins);
    repeat (4) begin
      @(posedge clk);
      v = osc;
      #1 chk("clock_buffer_out", {3'h0, v}, {3'h0, cbo});
    end
    raw <= 3'h0;
    i_dpc_host_model.wr(1'b1, 4'h1);
    repeat (2) @(posedge clk);
    chk("pins", 4'h8, pins);
    i_dpc_host_model.wr(1'b0, 4'h3);
    repeat (2) @(posedge clk);
    chk("txd", 4'h3, txd);
    i_dpc_host_model.rd(1'b1, hv, ho);
    chk("host status", 4'h0, hv);
    chk("host oe", 4'h1, {3'h0, ho});
    boot(1'b1);
    i_dpc_host_model.wr(1'b0, 4'h9);
    i_dpc_host_model.wr(1'b1, 4'h2);
    repeat (2) @(posedge clk);
    chk("txd", 4'h9, txd);
    chk("pins", 4'h4, pins);
    // Status read in power-down tells status apart from the cleared digit
    pd <= 1'b1;
    i_dpc_host_model.rd(1'b1, hv, ho);
    chk("host oe", 4'h1, {3'h0, ho});
    chk("host status", 4'h8, hv);
    pd <= 1'b0;
    rdc("cfg", ADDR_CFG, 32'h1);
    summarize();
  end
endmodule // test_dtmf_power_and_host_mode_ctrl
